/* File: hw/sbc_defines.vh */
// Command encodings, field positions and timing counts for the bank command control
`ifndef SBC_DEFINES_VH
`define SBC_DEFINES_VH
// Command code {cs_n, ras_n, cas_n, we_n}
`define SBC_CMD_NOP 4'h7
`define SBC_CMD_ACT 4'h3
`define SBC_CMD_READ 4'h5
`define SBC_CMD_WRITE 4'h4
`define SBC_CMD_STOP 4'h6
`define SBC_CMD_PRE 4'h2
`define SBC_CMD_REF 4'h1
`define SBC_CMD_MRS 4'h0
// Address field positions
`define SBC_AP_BIT 10
`define SBC_COL_W 9
// Burst length codes
`define SBC_BL_1 3'h0
`define SBC_BL_2 3'h1
`define SBC_BL_4 3'h2
`define SBC_BL_8 3'h3
`define SBC_BL_PAGE 3'h7
// Write recovery in clocks and precharge time in ns
`define SBC_WR_CLK 1
`define SBC_TRP_NS 20
`define SBC_CLK_NS 8
`define SBC_TRP_CYC ((`SBC_TRP_NS + `SBC_CLK_NS - 1) / `SBC_CLK_NS)
// Reset value of bank state
`define SBC_BANKS_RST 4'h0
`endif

/* File: hw/sbc_col_gen.v */
// Burst column address generator for sequential and interleave order
`timescale 1ns/1ps
`include "sbc_defines.vh"
module sbc_col_gen #(
    parameter COL_W = `SBC_COL_W
) (
    input wire [COL_W-1:0] start_col_in,
    input wire [COL_W-1:0] beat_in,
    input wire [2:0] burst_len_in,
    input wire interleave_in,
    output reg [COL_W-1:0] col_out
);
    reg [COL_W-1:0] mask;
    reg [COL_W-1:0] seq;
    always @* begin
        mask = {COL_W{1'b0}};
        case (burst_len_in)
            `SBC_BL_2: mask = {{(COL_W-1){1'b0}}, 1'b1};
            `SBC_BL_4: mask = {{(COL_W-2){1'b0}}, 2'h3};
            `SBC_BL_8: mask = {{(COL_W-3){1'b0}}, 3'h7};
            `SBC_BL_PAGE: mask = {COL_W{1'b1}};
            default: mask = {COL_W{1'b0}};
        endcase
        seq = start_col_in + beat_in;
        if (interleave_in && burst_len_in != `SBC_BL_PAGE) begin
            col_out = start_col_in ^ (beat_in & mask);
        end else begin
            // Low bits wrap, no carry into upper bits
            col_out = (start_col_in & ~mask) | (seq & mask);
        end
    end
endmodule // sbc_col_gen

/* File: hw/sbc_cmd_decode.v */
// Command decoder from control pins
`timescale 1ns/1ps
`include "sbc_defines.vh"
module sbc_cmd_decode (
    input wire cs_n_in,
    input wire ras_n_in,
    input wire cas_n_in,
    input wire we_n_in,
    output reg [3:0] cmd_out
);
    always @* begin
        if (cs_n_in) begin
            cmd_out = `SBC_CMD_NOP;
        end else begin
            cmd_out = {1'b0, ras_n_in, cas_n_in, we_n_in};
        end
    end
endmodule // sbc_cmd_decode

/* File: hw/sbc_bank_ctrl.v */
// Bank command control: burst, precharge, refresh, power-down and suspend
`timescale 1ns/1ps
`include "sbc_defines.vh"
module sbc_bank_ctrl #(
    parameter COL_W = `SBC_COL_W,
    parameter WR_CLK = `SBC_WR_CLK,
    parameter TRP_CYC = `SBC_TRP_CYC
) (
    input wire clk_in,
    input wire rst_n_in,
    input wire cke_in,
    input wire cs_n_in,
    input wire ras_n_in,
    input wire cas_n_in,
    input wire we_n_in,
    input wire bank_select_lo_in,
    input wire bank_select_hi_in,
    input wire [12:0] addr_in,
    input wire [2:0] burst_len_in,
    input wire interleave_in,
    input wire [1:0] cas_latency_in,
    output reg [3:0] bank_open_out,
    output reg [3:0] bank_precharging_out,
    output reg burst_active_out,
    output reg burst_write_out,
    output reg [1:0] burst_bank_out,
    output reg [COL_W-1:0] burst_col_out,
    output reg write_take_out,
    output reg self_refresh_out,
    output reg power_down_out,
    output reg suspend_out
);
    localparam ST_RUN = 2'h0;
    localparam ST_SREF = 2'h1;
    localparam ST_PDN = 2'h2;
    localparam ST_SUSP = 2'h3;

    reg rst_meta;
    reg rst_sync;
    reg [1:0] state;
    reg [1:0] next_state;
    reg cke_prev;
    reg [COL_W-1:0] start_col;
    reg [COL_W-1:0] beat;
    reg [COL_W-1:0] beats_left;
    reg auto_pre;
    reg [3:0] ap_delay;
    reg ap_pending;
    reg [3:0] trp_cnt [0:3];
    reg [3:0] pre_start;
    reg ap_fire;
    wire [3:0] cmd;
    wire [1:0] bank_sel;
    wire [COL_W-1:0] col_now;
    wire [COL_W-1:0] col_cmd;
    wire any_open;
    wire clk_live;
    wire is_rw;
    wire last_beat;
    wire cke_fall;
    integer i;
    integer j;
    integer m;

    function [COL_W-1:0] burst_beats;
        input [2:0] bl;
        begin
            case (bl)
                `SBC_BL_1: burst_beats = {{(COL_W-1){1'b0}}, 1'b1};
                `SBC_BL_2: burst_beats = {{(COL_W-2){1'b0}}, 2'h2};
                `SBC_BL_4: burst_beats = {{(COL_W-3){1'b0}}, 3'h4};
                `SBC_BL_8: burst_beats = {{(COL_W-4){1'b0}}, 4'h8};
                default: burst_beats = {COL_W{1'b1}};
            endcase
        end
    endfunction

    // Precharge target: every bank when the flag bit is set
    function bank_hit;
        input [1:0] sel;
        input [1:0] idx;
        input all;
        begin
            bank_hit = all || (sel == idx);
        end
    endfunction

    sbc_cmd_decode u_dec (
        .cs_n_in(cs_n_in),
        .ras_n_in(ras_n_in),
        .cas_n_in(cas_n_in),
        .we_n_in(we_n_in),
        .cmd_out(cmd)
    );

    sbc_col_gen #(
        .COL_W(COL_W)
    ) u_col (
        .start_col_in(start_col),
        .beat_in(beat),
        .burst_len_in(burst_len_in),
        .interleave_in(interleave_in),
        .col_out(col_now)
    );

    assign bank_sel = {bank_select_hi_in, bank_select_lo_in};
    assign col_cmd = addr_in[COL_W-1:0];
    assign any_open = |bank_open_out;
    // Internal clock gated off outside the run state
    assign clk_live = (state == ST_RUN) && cke_prev;
    assign is_rw = (cmd == `SBC_CMD_READ) || (cmd == `SBC_CMD_WRITE);
    assign last_beat = (beats_left == {{(COL_W-1){1'b0}}, 1'b1});
    assign cke_fall = cke_prev && !cke_in;

    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rst_meta <= 1'b0;
            rst_sync <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_sync <= rst_meta;
        end
    end

    // Power state; pins are same-clock logic from the controller
    always @* begin
        next_state = state;
        case (state)
            ST_RUN: begin
                if (cke_fall && cmd == `SBC_CMD_REF && !any_open) begin
                    next_state = ST_SREF;
                end else if (cke_fall) begin
                    // Burst or open bank suspends instead of power-down
                    if (any_open || burst_active_out) begin
                        next_state = ST_SUSP;
                    end else begin
                        next_state = ST_PDN;
                    end
                end
            end
            ST_SREF: begin
                if (cke_in) begin
                    next_state = ST_RUN;
                end
            end
            ST_PDN: begin
                if (cke_in) begin
                    next_state = ST_RUN;
                end
            end
            ST_SUSP: begin
                if (cke_in) begin
                    next_state = ST_RUN;
                end
            end
            default: next_state = ST_RUN;
        endcase
    end

    // Power state registers keep running while the internal clock is off
    always @(posedge clk_in or negedge rst_sync) begin
        if (!rst_sync) begin
            state <= ST_RUN;
            cke_prev <= 1'b1;
            self_refresh_out <= 1'b0;
            power_down_out <= 1'b0;
            suspend_out <= 1'b0;
        end else begin
            state <= next_state;
            cke_prev <= cke_in;
            self_refresh_out <= (next_state == ST_SREF);
            power_down_out <= (next_state == ST_PDN);
            suspend_out <= (next_state == ST_SUSP);
        end
    end

    // Banks whose precharge time starts at this edge
    always @* begin
        ap_fire = clk_live && ap_pending && (ap_delay == 4'h0);
        pre_start = 4'h0;
        if (ap_fire) begin
            pre_start[burst_bank_out] = 1'b1;
        end
        for (j = 0; j < 4; j = j + 1) begin
            // Flag bit set: all banks, else the selected one
            if (clk_live && cmd == `SBC_CMD_PRE &&
                bank_hit(bank_sel, j[1:0], addr_in[`SBC_AP_BIT])) begin
                pre_start[j] = 1'b1;
            end
        end
    end

    // Precharge time per bank; activate is refused until it runs out
    always @(posedge clk_in or negedge rst_sync) begin
        if (!rst_sync) begin
            bank_precharging_out <= `SBC_BANKS_RST;
            for (m = 0; m < 4; m = m + 1) begin
                trp_cnt[m] <= 4'h0;
            end
        end else if (clk_live) begin
            for (m = 0; m < 4; m = m + 1) begin
                if (pre_start[m]) begin
                    bank_precharging_out[m] <= 1'b1;
                    trp_cnt[m] <= TRP_CYC[3:0];
                end else if (trp_cnt[m] != 4'h0) begin
                    trp_cnt[m] <= trp_cnt[m] - 4'h1;
                end else begin
                    bank_precharging_out[m] <= 1'b0;
                end
            end
        end
    end

    // Auto precharge timing; a write first waits out the recovery clocks
    always @(posedge clk_in or negedge rst_sync) begin
        if (!rst_sync) begin
            ap_pending <= 1'b0;
            ap_delay <= 4'h0;
        end else if (clk_live) begin
            if (ap_pending) begin
                if (ap_delay != 4'h0) begin
                    ap_delay <= ap_delay - 4'h1;
                end else begin
                    ap_pending <= 1'b0;
                end
            end else if (burst_active_out && auto_pre && !burst_write_out &&
                         beats_left == {{(COL_W-2){1'b0}}, cas_latency_in}) begin
                // Read precharge leads the burst end by two clocks less than the CAS latency
                ap_pending <= 1'b1;
                ap_delay <= 4'h0;
            end else if (burst_active_out && auto_pre && burst_write_out && last_beat) begin
                ap_pending <= 1'b1;
                ap_delay <= WR_CLK[3:0];
            end
        end
    end

    always @(posedge clk_in or negedge rst_sync) begin
        if (!rst_sync) begin
            bank_open_out <= `SBC_BANKS_RST;
            burst_active_out <= 1'b0;
            burst_write_out <= 1'b0;
            burst_bank_out <= 2'h0;
            burst_col_out <= {COL_W{1'b0}};
            write_take_out <= 1'b0;
            start_col <= {COL_W{1'b0}};
            beat <= {COL_W{1'b0}};
            beats_left <= {COL_W{1'b0}};
            auto_pre <= 1'b0;
        end else begin
            write_take_out <= 1'b0;
            if (clk_live) begin
                // Burst advance; no-operation leaves it running
                if (burst_active_out) begin
                    beat <= beat + {{(COL_W-1){1'b0}}, 1'b1};
                    burst_col_out <= col_now;
                    beats_left <= beats_left - {{(COL_W-1){1'b0}}, 1'b1};
                    if (burst_write_out) begin
                        write_take_out <= 1'b1;
                    end
                    if (last_beat &&
                        burst_len_in != `SBC_BL_PAGE) begin
                        burst_active_out <= 1'b0;
                        write_take_out <= 1'b0;
                    end
                end

                if (ap_fire) begin
                    auto_pre <= 1'b0;
                    bank_open_out[burst_bank_out] <= 1'b0;
                end

                // Commands; controller keeps auto precharge bursts whole
                if (cmd == `SBC_CMD_ACT && !bank_precharging_out[bank_sel]) begin
                    bank_open_out[bank_sel] <= 1'b1;
                end else if (is_rw && bank_open_out[bank_sel] && !auto_pre) begin
                    burst_active_out <= 1'b1;
                    burst_write_out <= (cmd == `SBC_CMD_WRITE);
                    burst_bank_out <= bank_sel;
                    start_col <= col_cmd;
                    burst_col_out <= col_cmd;
                    beat <= {{(COL_W-1){1'b0}}, 1'b1};
                    beats_left <= burst_beats(burst_len_in);
                    auto_pre <= addr_in[`SBC_AP_BIT];
                    // First write word taken with the command
                    write_take_out <= (cmd == `SBC_CMD_WRITE);
                    if (burst_len_in == `SBC_BL_1) begin
                        beats_left <= {{(COL_W-1){1'b0}}, 1'b1};
                    end
                end else if (cmd == `SBC_CMD_STOP &&
                             burst_len_in == `SBC_BL_PAGE) begin
                    // Residual page write data is dropped
                    burst_active_out <= 1'b0;
                    write_take_out <= 1'b0;
                end else if (cmd == `SBC_CMD_PRE) begin
                    for (i = 0; i < 4; i = i + 1) begin
                        if (pre_start[i]) begin
                            bank_open_out[i] <= 1'b0;
                        end
                    end
                    if (bank_hit(bank_sel, burst_bank_out, addr_in[`SBC_AP_BIT])) begin
                        burst_active_out <= 1'b0;
                    end
                end
            end
        end
    end
endmodule // sbc_bank_ctrl

/* File: verif/sbc_bank_ctrl_assertions.sv */
// Port-level assertions for the bank command control
`timescale 1ns/1ps
`include "sbc_defines.vh"
module sbc_bank_ctrl_assertions #(
    parameter COL_W = `SBC_COL_W
) (
    input wire clk_in,
    input wire rst_n_in,
    input wire cke_in,
    input wire cs_n_in,
    input wire ras_n_in,
    input wire cas_n_in,
    input wire we_n_in,
    input wire bank_select_lo_in,
    input wire bank_select_hi_in,
    input wire [12:0] addr_in,
    input wire [2:0] burst_len_in,
    input wire interleave_in,
    input wire [3:0] bank_open_out,
    input wire burst_active_out,
    input wire [COL_W-1:0] burst_col_out,
    input wire self_refresh_out,
    input wire power_down_out,
    input wire suspend_out
);
    reg cke_d;
    wire [3:0] cmd = {cs_n_in, ras_n_in, cas_n_in, we_n_in};
    wire [3:0] bank_bit = 4'h1 << {bank_select_hi_in, bank_select_lo_in};
    // Internal clock live: enable high last edge and no power state
    wire run = cke_d && !suspend_out && !power_down_out && !self_refresh_out;
    wire quiet = cs_n_in || cmd == `SBC_CMD_NOP;
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cke_d <= 1'b0;
        end else begin
            cke_d <= cke_in;
        end
    end
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    property p_pre_one;
        run && cke_in && cmd == `SBC_CMD_PRE && !addr_in[10] && !burst_active_out
        |=> bank_open_out == ($past(bank_open_out) & ~$past(bank_bit));
    endproperty
    a_pre_one: assert property (p_pre_one) else $error("single precharge wrong");
    property p_pre_all;
        run && cke_in && cmd == `SBC_CMD_PRE && addr_in[10] && !burst_active_out
        |=> bank_open_out == 4'h0;
    endproperty
    a_pre_all: assert property (p_pre_all) else $error("all-bank precharge wrong");
    property p_deselect;
        run && cke_in && cs_n_in
        |=> !$rose(burst_active_out) && (bank_open_out & ~$past(bank_open_out)) == 4'h0;
    endproperty
    a_deselect: assert property (p_deselect) else $error("deselect acted");
    property p_seq_beat;
        run && cke_in && burst_active_out && !interleave_in && burst_len_in == `SBC_BL_4
        && (cs_n_in || cas_n_in) ##1 burst_active_out
        |-> burst_col_out[1:0] == $past(burst_col_out[1:0]) + 2'h1
        && burst_col_out[COL_W-1:2] == $past(burst_col_out[COL_W-1:2]);
    endproperty
    a_seq_beat: assert property (p_seq_beat) else $error("sequential column wrong");
    property p_sref_entry;
        run && !cke_in && cmd == `SBC_CMD_REF && bank_open_out == 4'h0 && !burst_active_out
        |=> self_refresh_out;
    endproperty
    a_sref_entry: assert property (p_sref_entry) else $error("no self refresh");
    property p_sref_hold;
        self_refresh_out && !cke_in |=> self_refresh_out && $stable(bank_open_out);
    endproperty
    a_sref_hold: assert property (p_sref_hold) else $error("self refresh left");
    property p_suspend_entry;
        run && !cke_in && (bank_open_out != 4'h0 || burst_active_out) |-> ##[1:2] suspend_out;
    endproperty
    a_suspend_entry: assert property (p_suspend_entry) else $error("no suspend");
    property p_pd_entry;
        run && !cke_in && quiet && bank_open_out == 4'h0 && !burst_active_out
        |-> ##[1:2] power_down_out;
    endproperty
    a_pd_entry: assert property (p_pd_entry) else $error("no power-down");
endmodule // sbc_bank_ctrl_assertions
bind sbc_bank_ctrl sbc_bank_ctrl_assertions #(.COL_W(COL_W)) u_chk (.clk_in, .rst_n_in,
    .cke_in, .cs_n_in, .ras_n_in, .cas_n_in, .we_n_in, .bank_select_lo_in, .bank_select_hi_in,
    .addr_in, .burst_len_in, .interleave_in, .bank_open_out, .burst_active_out,
    .burst_col_out, .self_refresh_out, .power_down_out, .suspend_out);

/* File: verif/sbc_ctrl_model.sv */
// Memory controller model driving the command pins
`timescale 1ns/1ps
`include "sbc_defines.vh"
module sbc_ctrl_model (
    input wire clk_in,
    input wire cke_req_in,
    input wire [3:0] cmd_in,
    input wire [1:0] bank_in,
    input wire [12:0] addr_in,
    output wire cke_out,
    output wire cs_n_out,
    output wire ras_n_out,
    output wire cas_n_out,
    output wire we_n_out,
    output wire bank_select_lo_out,
    output wire bank_select_hi_out,
    output wire [12:0] addr_out
);
    reg cke_d = 1'b0;
    // First edge after enable rises carries a no-operation
    wire wake = cke_req_in && !cke_d;
    wire [3:0] cmd = wake ? `SBC_CMD_NOP : cmd_in;
    // Address and bank lines on deselect and no-operation show the inverse of the requested value
    wire idle = cmd[3] || cmd == `SBC_CMD_NOP;
    always @(posedge clk_in) begin
        cke_d <= cke_req_in;
    end
    assign cke_out = cke_req_in;
    assign {cs_n_out, ras_n_out, cas_n_out, we_n_out} = cmd;
    assign {bank_select_hi_out, bank_select_lo_out} = idle ? ~bank_in : bank_in;
    assign addr_out = idle ? ~addr_in : addr_in;
endmodule // sbc_ctrl_model

/* File: verif/tb.sv */
// Self-checking bench for the bank command control
`timescale 1ns/1ps
`include "sbc_defines.vh"
module tb;
    reg clk_in = 1'b0;
    reg rst_n_in = 1'b0;
    reg cke = 1'b1;
    reg [3:0] cmd = `SBC_CMD_NOP;
    reg [1:0] bank = 2'h0;
    reg [12:0] addr = 13'h0000;
    reg [2:0] bl = `SBC_BL_4;
    reg il = 1'b0;
    reg [1:0] cl = 2'h2;
    wire cke_p, cs_n, ras_n, cas_n, we_n, bs_lo, bs_hi, act, wr, take, sref, pdn, susp;
    wire [12:0] addr_p;
    wire [3:0] open, prech;
    wire [1:0] bbank;
    wire [8:0] col;
    integer fails = 0;
    integer compares = 0;
    integer cycles = 0;
    integer i, k, n;
    reg [8:0] hold;
    // Rows: beats expected, burst length code, interleave, start column
    reg [16:0] rows [0:7] = '{17'h045ff, 17'h08806, 17'h10cfd, 17'h046a1,
        17'h08b05, 17'h10e13, 17'h02003, 17'h10ffe};
    sbc_ctrl_model ctrl (.clk_in(clk_in), .cke_req_in(cke), .cmd_in(cmd), .bank_in(bank),
        .addr_in(addr), .cke_out(cke_p), .cs_n_out(cs_n), .ras_n_out(ras_n),
        .cas_n_out(cas_n), .we_n_out(we_n), .bank_select_lo_out(bs_lo),
        .bank_select_hi_out(bs_hi), .addr_out(addr_p));
    sbc_bank_ctrl dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .cke_in(cke_p), .cs_n_in(cs_n),
        .ras_n_in(ras_n), .cas_n_in(cas_n), .we_n_in(we_n), .bank_select_lo_in(bs_lo),
        .bank_select_hi_in(bs_hi), .addr_in(addr_p), .burst_len_in(bl), .interleave_in(il),
        .cas_latency_in(cl), .bank_open_out(open), .bank_precharging_out(prech),
        .burst_active_out(act), .burst_write_out(wr), .burst_bank_out(bbank),
        .burst_col_out(col), .write_take_out(take), .self_refresh_out(sref),
        .power_down_out(pdn), .suspend_out(susp));
    always #4 clk_in = ~clk_in;
    always @(posedge clk_in) begin
        cycles = cycles + 1;
        if (cycles == 2000) begin
            fails = fails + 1;
            end_sim;
        end
    end
    task end_sim;
        begin
            if (fails == 0 && compares > 0) $display("Run complete: PASS");
            else $display("Run complete: FAIL");
            $finish;
        end
    endtask
    task check(input [31:0] seen, input [31:0] exp);
        begin
            compares = compares + 1;
            if (seen !== exp) begin
                fails = fails + 1;
                $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task tick(input integer m);
        begin
            repeat (m) @(posedge clk_in);
            #1;
        end
    endtask
    // Command held one cycle, then a no-operation; returns after the command edge
    task go(input [3:0] c, input [1:0] b, input [12:0] a);
        begin
            @(posedge clk_in);
            cmd <= c;
            bank <= b;
            addr <= a;
            @(posedge clk_in);
            cmd <= `SBC_CMD_NOP;
            #1;
        end
    endtask
    function [8:0] exp_col(input [8:0] s, input [3:0] k, input [3:0] n, input x);
        exp_col = x ? s ^ k : (s & ~(n - 4'h1)) | ((s + k) & (n - 4'h1));
    endfunction
    task burst(input [3:0] c, input [1:0] b, input [12:0] a, input [3:0] n, input x);
        begin
            go(c, b, a);
            for (k = 0; k < n; k = k + 1) begin
                check({act, wr, bbank}, {1'h1, c == `SBC_CMD_WRITE, b});
                check(col, exp_col(a[8:0], k, n, x));
                check(take, c == `SBC_CMD_WRITE);
                tick(1);
            end
            check(act, 1'h0);
        end
    endtask
    initial begin
        repeat (2) @(posedge clk_in);
        rst_n_in <= 1'b1;
        tick(3);
        check({open, prech, act, take, sref, pdn, susp}, 16'h0000);
        go(`SBC_CMD_ACT, 2'h1, 13'h0000);
        check(open, 4'h2);
        for (i = 0; i < 8; i = i + 1) begin
            @(posedge clk_in);
            bl <= rows[i][12:10];
            il <= rows[i][9];
            burst(i[0] ? `SBC_CMD_READ : `SBC_CMD_WRITE, 2'h1, {4'h0, rows[i][8:0]},
                rows[i][16:13], rows[i][9]);
        end
        @(posedge clk_in);
        bl <= `SBC_BL_PAGE;
        il <= 1'b0;
        go(`SBC_CMD_WRITE, 2'h1, 13'h0010);
        go(4'h8, 2'h1, 13'h0000);
        check(act, 1'h1);
        go(`SBC_CMD_STOP, 2'h1, 13'h0000);
        check({act, take, open}, 6'h02);
        @(posedge clk_in);
        bl <= `SBC_BL_4;
        go(`SBC_CMD_WRITE, 2'h1, 13'h0020);
        go(`SBC_CMD_STOP, 2'h1, 13'h0000);
        check({act, col}, 10'h222);
        tick(2);
        check(act, 1'h0);
        go(`SBC_CMD_ACT, 2'h0, 13'h0000);
        go(`SBC_CMD_ACT, 2'h2, 13'h0000);
        check(open, 4'h7);
        go(`SBC_CMD_PRE, 2'h2, 13'h0000);
        check({open, prech[2]}, 5'h07);
        go(`SBC_CMD_ACT, 2'h2, 13'h0000);
        check(open, 4'h3);
        tick(`SBC_TRP_CYC);
        go(`SBC_CMD_ACT, 2'h2, 13'h0000);
        check(open, 4'h7);
        // No command until the auto precharge burst completes
        burst(`SBC_CMD_WRITE, 2'h0, 13'h0408, 4'h4, 1'b0);
        for (n = 0; n < 4 && open[0] !== 1'b0; n = n + 1) tick(1);
        check(open[0], 1'h0);
        @(posedge clk_in);
        cl <= 2'h3;
        go(`SBC_CMD_READ, 2'h2, 13'h0400);
        tick(3);
        check({act, open[2]}, 2'h2);
        tick(2);
        @(posedge clk_in);
        bl <= `SBC_BL_8;
        go(`SBC_CMD_WRITE, 2'h1, 13'h0000);
        @(posedge clk_in);
        cke <= 1'b0;
        tick(3);
        hold = col;
        go(`SBC_CMD_ACT, 2'h3, 13'h0000);
        check({susp, col, open[3]}, {1'h1, hold, 1'h0});
        @(posedge clk_in);
        cke <= 1'b1;
        tick(3);
        check({susp, act}, 2'h1);
        for (n = 0; n < 10 && act !== 1'b0; n = n + 1) tick(1);
        go(`SBC_CMD_PRE, 2'h3, 13'h0400);
        check(open, 4'h0);
        tick(`SBC_TRP_CYC);
        @(posedge clk_in);
        cke <= 1'b0;
        tick(3);
        go(`SBC_CMD_ACT, 2'h0, 13'h0000);
        check({pdn, open}, 5'h10);
        @(posedge clk_in);
        cke <= 1'b1;
        tick(3);
        check(pdn, 1'h0);
        // No auto refresh bursts are used around self refresh
        @(posedge clk_in);
        cmd <= `SBC_CMD_REF;
        cke <= 1'b0;
        @(posedge clk_in);
        cmd <= `SBC_CMD_NOP;
        tick(2);
        go(`SBC_CMD_ACT, 2'h1, 13'h0000);
        check({sref, open}, 5'h10);
        @(posedge clk_in);
        cke <= 1'b1;
        tick(4);
        check(sref, 1'h0);
        go(`SBC_CMD_ACT, 2'h1, 13'h0000);
        check(open, 4'h2);
        @(posedge clk_in);
        rst_n_in <= 1'b0;
        tick(2);
        check({open, act}, 5'h00);
        @(posedge clk_in);
        rst_n_in <= 1'b1;
        tick(3);
        go(`SBC_CMD_ACT, 2'h3, 13'h0000);
        check(open, 4'h8);
        end_sim;
    end
endmodule // tb
